//--- verilog/ppo_defines.vh
`ifndef PPO_DEFINES_VH
`define PPO_DEFINES_VH

// Register indices; byte address is four times the index
`define PPO_IX_B_SAMPLE 5'h03
`define PPO_IX_B_DIR 5'h04
`define PPO_IX_B_DATA 5'h05
`define PPO_IX_C_SAMPLE 5'h06
`define PPO_IX_C_DIR 5'h07
`define PPO_IX_C_DATA 5'h08
`define PPO_IX_D_SAMPLE 5'h09
`define PPO_IX_D_DIR 5'h0A
`define PPO_IX_D_DATA 5'h0B
`define PPO_IX_CORE_CTRL 5'h0C
`define PPO_IX_IRQ_STATUS 5'h0D
`define PPO_IX_IRQ_MASK 5'h0E
`define PPO_IX_PC_MASK 5'h0F
`define PPO_IX_PC_CTRL 5'h10

// Field positions
`define PPO_BIT_PULLUP_OFF 4
`define PPO_BIT_PC_GROUP1 1
`define PPO_BIT_PC_GROUP2 2
`define PPO_PC_C_UNUSED 7
`define PPO_PD_RX 0
`define PPO_PD_TX 1
`define PPO_PD_EXT0 2
`define PPO_PD_EXT1 3
`define PPO_PD_SCK 4
`define PPO_PD_T0B 5
`define PPO_PD_T0A 6
`define PPO_PD_T2B 3

// Reset values
`define PPO_RST_BYTE 8'h00
`define PPO_RST_C 7'h00

// Bus answers
`define PPO_RESP_OKAY 2'h0
`define PPO_RESP_SLVERR 2'h2

`endif

//--- verilog/ppo_port_pin_override.v
// How it works
// RULE1: Transmitter forces pin D1 output, value, pull-up off
// RULE2: Receiver forces pin D0 to input
// RULE3: Forced D0 input keeps data-bit pull-up control
// RULE4: Global pull-up disable kills all pull-ups
// RULE5: Software sets D3 direction for compare output
// RULE6: D3, D2 serve external interrupts one, zero
// RULE7: Port D pins map to change sources 16-23
// RULE8: D6, D5 compare outputs; D4 serial clock
// RULE9: Change mask or external enable forces input
// RULE10: Sample registers read-only, return pin levels
// RULE11: Port C data seven bits, bit 7 zero
// RULE12: Port D direction eight bits, one is output
// RULE13: Port C bit 7 writes ignored, reads zero
`include "ppo_defines.vh"
`default_nettype none

module ppo_port_pin_override #(
	parameter ADDR_W = 8
) (
	input wire I_CLOCK,
	input wire I_RSTN,
	input wire [ADDR_W-1:0] I_AWADDR,
	input wire I_AWVALID,
	output wire O_AWREADY,
	input wire [31:0] I_WDATA,
	input wire [3:0] I_WSTRB,
	input wire I_WVALID,
	output wire O_WREADY,
	output wire [1:0] O_BRESP,
	output wire O_BVALID,
	input wire I_BREADY,
	input wire [ADDR_W-1:0] I_ARADDR,
	input wire I_ARVALID,
	output wire O_ARREADY,
	output wire [31:0] O_RDATA,
	output wire [1:0] O_RRESP,
	output wire O_RVALID,
	input wire I_RREADY,
	input wire [7:0] I_PB_IN,
	input wire [6:0] I_PC_IN,
	input wire [7:0] I_PD_IN,
	input wire I_SLEEP,
	input wire I_TRANSMITTER_ON,
	input wire I_TX_DATA,
	input wire I_RECEIVER_ON,
	input wire I_SYNC_MODE_SELECT,
	input wire I_SERIAL_CLOCK_OUT,
	input wire I_TIMER0_COMPARE_A_EN,
	input wire I_TIMER0_COMPARE_A_OUT,
	input wire I_TIMER0_COMPARE_B_EN,
	input wire I_TIMER0_COMPARE_B_OUT,
	input wire I_TIMER2_COMPARE_B_EN,
	input wire I_TIMER2_COMPARE_B_OUT,
	input wire I_EXT_IRQ_ZERO_EN,
	input wire I_EXT_IRQ_ONE_EN,
	output wire [7:0] O_PB_OUT,
	output wire [7:0] O_PB_OE_N,
	output wire [7:0] O_PB_PULLUP,
	output wire [6:0] O_PC_OUT,
	output wire [6:0] O_PC_OE_N,
	output wire [6:0] O_PC_PULLUP,
	output wire [7:0] O_PD_OUT,
	output wire [7:0] O_PD_OE_N,
	output wire [7:0] O_PD_PULLUP,
	output wire [23:16] O_PIN_CHANGE_SRC,
	output wire O_EXT_IRQ_ZERO_IN,
	output wire O_EXT_IRQ_ONE_IN,
	output wire O_RX_DATA,
	output wire O_IRQ
);

	// Synchronisers; first stage feeds only the second
	reg [7:0] sync1_b_r;
	reg [7:0] sync2_b_r;
	reg [6:0] sync1_c_r;
	reg [6:0] sync2_c_r;
	reg [7:0] sync1_d_r;
	reg [7:0] sync2_d_r;

	reg [7:0] port_b_direction_r, port_b_output_data_r;
	reg [6:0] port_c_direction_r, port_c_output_data_r;
	reg [7:0] port_d_direction_r, port_d_output_data_r;
	reg [7:0] port_b_pin_sample_r;
	reg [6:0] port_c_pin_sample_r;
	reg [7:0] port_d_pin_sample_r;
	reg [7:0] core_control_r;
	reg [7:0] irq_status_r, irq_mask_r;
	reg [7:0] pin_change_mask_r, pin_change_ctrl_r;

	reg [7:0] pb_out_r, pb_oe_n_r, pb_pu_r;
	reg [6:0] pc_out_r, pc_oe_n_r, pc_pu_r;
	reg [7:0] pd_out_r, pd_oe_n_r, pd_pu_r;
	reg irq_r;

	reg aw_held_r;
	reg w_held_r;
	reg bvalid_r;
	reg rvalid_r;
	// Ready outputs are flops too, loaded with their next value
	reg awready_r;
	reg wready_r;
	reg arready_r;
	reg [4:0] aw_idx_r;
	reg [7:0] wdata_r;
	reg wstrb0_r;
	reg [1:0] bresp_r, rresp_r;
	reg [7:0] rdata_r;

	wire pullup_off = core_control_r[`PPO_BIT_PULLUP_OFF];
	wire pc_group2 = pin_change_ctrl_r[`PPO_BIT_PC_GROUP2];

	// Pin override logic for port D
	reg [7:0] pd_dir, pd_val, pd_pu, pd_die_ovr;
	always @* begin
		pd_dir = port_d_direction_r; // RULE12
		pd_val = port_d_output_data_r;
		if (I_TRANSMITTER_ON) begin
			pd_dir[`PPO_PD_TX] = 1'b1; // RULE1
			pd_val[`PPO_PD_TX] = I_TX_DATA; // RULE1
		end
		if (I_RECEIVER_ON)
			pd_dir[`PPO_PD_RX] = 1'b0; // RULE2
		// Direction stays with software: override only the value
		if (I_TIMER2_COMPARE_B_EN)
			pd_val[`PPO_PD_T2B] = I_TIMER2_COMPARE_B_OUT; // RULE5
		if (I_TIMER0_COMPARE_A_EN)
			pd_val[`PPO_PD_T0A] = I_TIMER0_COMPARE_A_OUT; // RULE8
		if (I_TIMER0_COMPARE_B_EN)
			pd_val[`PPO_PD_T0B] = I_TIMER0_COMPARE_B_OUT; // RULE8
		if (I_SYNC_MODE_SELECT)
			pd_val[`PPO_PD_SCK] = I_SERIAL_CLOCK_OUT; // RULE8
		// D0 under the receiver keeps its data-bit pull-up path
		pd_pu = ~pd_dir & port_d_output_data_r &
			{8{~pullup_off}}; // RULE3 RULE4
		if (I_TRANSMITTER_ON)
			pd_pu[`PPO_PD_TX] = 1'b0; // RULE1
		pd_die_ovr = pin_change_mask_r & {8{pc_group2}}; // RULE9
		pd_die_ovr[`PPO_PD_EXT0] = pd_die_ovr[`PPO_PD_EXT0] |
			I_EXT_IRQ_ZERO_EN; // RULE6 RULE9
		pd_die_ovr[`PPO_PD_EXT1] = pd_die_ovr[`PPO_PD_EXT1] |
			I_EXT_IRQ_ONE_EN; // RULE6 RULE9
	end

	// Sleep gates digital inputs unless an override holds them on
	wire [7:0] pd_die = {8{~I_SLEEP}} | pd_die_ovr;
	wire [7:0] pd_sample_nxt = sync2_d_r & pd_die;
	wire [7:0] pc_event = (pd_sample_nxt ^ port_d_pin_sample_r) &
		pin_change_mask_r & {8{pc_group2}}; // RULE7

	// Bus decode
	wire aw_take = I_AWVALID & ~aw_held_r & ~bvalid_r;
	wire w_take = I_WVALID & ~w_held_r & ~bvalid_r;
	wire do_write = aw_held_r & w_held_r & ~bvalid_r;
	wire wr_en = do_write & wstrb0_r;
	wire ar_take = I_ARVALID & ~rvalid_r;
	wire [4:0] ar_idx = I_ARADDR[6:2];
	wire ar_hi = |(I_ARADDR >> 7);
	wire aw_ok = aw_idx_r >= `PPO_IX_B_SAMPLE &&
		aw_idx_r <= `PPO_IX_PC_CTRL;
	// Next handshake state, so the ready flops match the combined view
	wire aw_held_nxt = ~do_write & (aw_held_r | aw_take);
	wire w_held_nxt = ~do_write & (w_held_r | w_take);
	wire bvalid_nxt = do_write | (bvalid_r & ~I_BREADY);
	wire rvalid_nxt = ar_take | (rvalid_r & ~I_RREADY);

	wire [7:0] status_clr = (wr_en &&
		aw_idx_r == `PPO_IX_IRQ_STATUS) ? wdata_r : 8'h00;
	// A change in the same cycle as a clear stays set
	wire [7:0] irq_status_nxt = (irq_status_r & ~status_clr) |
		pc_event;

	reg [7:0] rd_val;
	reg rd_ok;
	always @* begin
		rd_ok = ~ar_hi;
		rd_val = `PPO_RST_BYTE;
		case (ar_idx)
		`PPO_IX_B_SAMPLE: rd_val = port_b_pin_sample_r; // RULE10
		`PPO_IX_B_DIR: rd_val = port_b_direction_r;
		`PPO_IX_B_DATA: rd_val = port_b_output_data_r;
		`PPO_IX_C_SAMPLE: rd_val = {1'b0, port_c_pin_sample_r};
		`PPO_IX_C_DIR: rd_val = {1'b0, port_c_direction_r}; // RULE13
		`PPO_IX_C_DATA:
			rd_val = {1'b0, port_c_output_data_r}; // RULE11 RULE13
		`PPO_IX_D_SAMPLE: rd_val = port_d_pin_sample_r; // RULE10
		`PPO_IX_D_DIR: rd_val = port_d_direction_r;
		`PPO_IX_D_DATA: rd_val = port_d_output_data_r;
		`PPO_IX_CORE_CTRL: rd_val = core_control_r;
		`PPO_IX_IRQ_STATUS: rd_val = irq_status_r;
		`PPO_IX_IRQ_MASK: rd_val = irq_mask_r;
		`PPO_IX_PC_MASK: rd_val = pin_change_mask_r;
		`PPO_IX_PC_CTRL: rd_val = pin_change_ctrl_r;
		default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge I_CLOCK) begin
		if (!I_RSTN) begin
			sync1_b_r <= `PPO_RST_BYTE;
			sync2_b_r <= `PPO_RST_BYTE;
			sync1_c_r <= `PPO_RST_C;
			sync2_c_r <= `PPO_RST_C;
			sync1_d_r <= `PPO_RST_BYTE;
			sync2_d_r <= `PPO_RST_BYTE;
			port_b_pin_sample_r <= `PPO_RST_BYTE;
			port_c_pin_sample_r <= `PPO_RST_C;
			port_d_pin_sample_r <= `PPO_RST_BYTE;
		end else begin
			sync1_b_r <= I_PB_IN;
			sync2_b_r <= sync1_b_r;
			sync1_c_r <= I_PC_IN;
			sync2_c_r <= sync1_c_r;
			sync1_d_r <= I_PD_IN;
			sync2_d_r <= sync1_d_r;
			port_b_pin_sample_r <= sync2_b_r & {8{~I_SLEEP}}; // RULE10
			port_c_pin_sample_r <= sync2_c_r & {7{~I_SLEEP}}; // RULE10
			port_d_pin_sample_r <= pd_sample_nxt; // RULE10
		end
	end

	// Register file
	always @(posedge I_CLOCK) begin
		if (!I_RSTN) begin
			port_b_direction_r <= `PPO_RST_BYTE;
			port_b_output_data_r <= `PPO_RST_BYTE;
			port_c_direction_r <= `PPO_RST_C;
			port_c_output_data_r <= `PPO_RST_C;
			port_d_direction_r <= `PPO_RST_BYTE;
			port_d_output_data_r <= `PPO_RST_BYTE;
			core_control_r <= `PPO_RST_BYTE;
			irq_status_r <= `PPO_RST_BYTE;
			irq_mask_r <= `PPO_RST_BYTE;
			pin_change_mask_r <= `PPO_RST_BYTE;
			pin_change_ctrl_r <= `PPO_RST_BYTE;
		end else begin
			irq_status_r <= irq_status_nxt;
			if (wr_en) begin
				case (aw_idx_r)
				`PPO_IX_B_DIR: port_b_direction_r <= wdata_r;
				`PPO_IX_B_DATA: port_b_output_data_r <= wdata_r;
				`PPO_IX_C_DIR:
					port_c_direction_r <= wdata_r[6:0]; // RULE13
				`PPO_IX_C_DATA:
					port_c_output_data_r <= wdata_r[6:0]; // RULE11
				`PPO_IX_D_DIR: port_d_direction_r <= wdata_r; // RULE12
				`PPO_IX_D_DATA: port_d_output_data_r <= wdata_r;
				`PPO_IX_CORE_CTRL: core_control_r <= wdata_r;
				`PPO_IX_IRQ_MASK: irq_mask_r <= wdata_r;
				`PPO_IX_PC_MASK: pin_change_mask_r <= wdata_r;
				`PPO_IX_PC_CTRL: pin_change_ctrl_r <= wdata_r;
				default: ;
				endcase
			end
		end
	end

	// AXI4-Lite slave; address and data may come in either order
	always @(posedge I_CLOCK) begin
		if (!I_RSTN) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			bvalid_r <= 1'b0;
			rvalid_r <= 1'b0;
			aw_idx_r <= 5'h00;
			wdata_r <= `PPO_RST_BYTE;
			wstrb0_r <= 1'b0;
			bresp_r <= `PPO_RESP_OKAY;
			rresp_r <= `PPO_RESP_OKAY;
			rdata_r <= `PPO_RST_BYTE;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= I_AWADDR[6:2];
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				wdata_r <= I_WDATA[7:0];
				wstrb0_r <= I_WSTRB[0];
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				// Sample registers are mapped but read-only
				bresp_r <= aw_ok ? `PPO_RESP_OKAY : `PPO_RESP_SLVERR;
			end else if (bvalid_r && I_BREADY)
				bvalid_r <= 1'b0;
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_val;
				rresp_r <= rd_ok ? `PPO_RESP_OKAY : `PPO_RESP_SLVERR;
			end else if (rvalid_r && I_RREADY)
				rvalid_r <= 1'b0;
		end
	end

	// Ready flags registered; reset leaves every channel open
	always @(posedge I_CLOCK) begin
		if (!I_RSTN) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
		end else begin
			awready_r <= ~aw_held_nxt & ~bvalid_nxt;
			wready_r <= ~w_held_nxt & ~bvalid_nxt;
			arready_r <= ~rvalid_nxt;
		end
	end

	// Pin drivers registered so pads never see decode glitches
	always @(posedge I_CLOCK) begin
		if (!I_RSTN) begin
			pb_out_r <= `PPO_RST_BYTE;
			pb_oe_n_r <= 8'hFF;
			pb_pu_r <= `PPO_RST_BYTE;
			pc_out_r <= `PPO_RST_C;
			pc_oe_n_r <= 7'h7F;
			pc_pu_r <= `PPO_RST_C;
			pd_out_r <= `PPO_RST_BYTE;
			pd_oe_n_r <= 8'hFF;
			pd_pu_r <= `PPO_RST_BYTE;
			irq_r <= 1'b0;
		end else begin
			pb_out_r <= port_b_output_data_r;
			pb_oe_n_r <= ~port_b_direction_r;
			pb_pu_r <= ~port_b_direction_r & port_b_output_data_r &
				{8{~pullup_off}}; // RULE4
			pc_out_r <= port_c_output_data_r;
			pc_oe_n_r <= ~port_c_direction_r;
			pc_pu_r <= ~port_c_direction_r & port_c_output_data_r &
				{7{~pullup_off}}; // RULE4
			pd_out_r <= pd_val;
			pd_oe_n_r <= ~pd_dir;
			pd_pu_r <= pd_pu;
			irq_r <= |(irq_status_nxt & irq_mask_r);
		end
	end

	assign O_AWREADY = awready_r;
	assign O_WREADY = wready_r;
	assign O_BVALID = bvalid_r;
	assign O_BRESP = bresp_r;
	assign O_ARREADY = arready_r;
	assign O_RVALID = rvalid_r;
	assign O_RRESP = rresp_r;
	assign O_RDATA = {24'h000000, rdata_r};
	assign O_PB_OUT = pb_out_r;
	assign O_PB_OE_N = pb_oe_n_r;
	assign O_PB_PULLUP = pb_pu_r;
	assign O_PC_OUT = pc_out_r;
	assign O_PC_OE_N = pc_oe_n_r;
	assign O_PC_PULLUP = pc_pu_r;
	assign O_PD_OUT = pd_out_r;
	assign O_PD_OE_N = pd_oe_n_r;
	assign O_PD_PULLUP = pd_pu_r;
	assign O_PIN_CHANGE_SRC = port_d_pin_sample_r; // RULE7
	assign O_EXT_IRQ_ZERO_IN = port_d_pin_sample_r[`PPO_PD_EXT0]; // RULE6
	assign O_EXT_IRQ_ONE_IN = port_d_pin_sample_r[`PPO_PD_EXT1]; // RULE6
	assign O_RX_DATA = port_d_pin_sample_r[`PPO_PD_RX];
	assign O_IRQ = irq_r;

endmodule // ppo_port_pin_override

`default_nettype wire

//--- verification/ppo_pins_model.sv
`default_nettype none
module ppo_pins_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_oe_n,
	input wire logic [W-1:0] i_pull,
	input wire logic [W-1:0] i_ext,
	output wire logic [W-1:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released pin: pull-up wins, else the board level
	assign o_pin = ~i_oe_n & i_out | i_oe_n & (i_pull | i_ext);
endmodule // ppo_pins_model
`default_nettype wire

//--- verification/ppo_port_pin_override_properties.sv
`default_nettype none
module ppo_port_pin_override_properties (
	input wire logic I_CLOCK,
	input wire logic I_RSTN,
	input wire logic I_TRANSMITTER_ON,
	input wire logic I_TX_DATA,
	input wire logic I_RECEIVER_ON,
	input wire logic I_SYNC_MODE_SELECT,
	input wire logic I_SERIAL_CLOCK_OUT,
	input wire logic I_TIMER0_COMPARE_A_EN,
	input wire logic I_TIMER0_COMPARE_A_OUT,
	input wire logic I_TIMER0_COMPARE_B_EN,
	input wire logic I_TIMER0_COMPARE_B_OUT,
	input wire logic I_TIMER2_COMPARE_B_EN,
	input wire logic I_TIMER2_COMPARE_B_OUT,
	input wire logic [7:0] O_PD_OUT,
	input wire logic [7:0] O_PD_OE_N,
	input wire logic [7:0] O_PD_PULLUP,
	input wire logic [23:16] O_PIN_CHANGE_SRC,
	input wire logic O_EXT_IRQ_ZERO_IN,
	input wire logic O_EXT_IRQ_ONE_IN
);
	logic run_r;
	// Pins are registered: a cause shows one edge later
	always @(posedge I_CLOCK) run_r <= I_RSTN;
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RSTN);
	property p_tx;
		run_r && $past(I_TRANSMITTER_ON) |-> !O_PD_OE_N[1] &&
			!O_PD_PULLUP[1] && O_PD_OUT[1] == $past(I_TX_DATA);
	endproperty
	a_tx: assert property (p_tx) else $error("tx pin wrong");
	property p_rx;
		run_r && $past(I_RECEIVER_ON) |-> O_PD_OE_N[0];
	endproperty
	a_rx: assert property (p_rx) else $error("rx pin drives");
	property p_timer2_compare_b_out;
		run_r && $past(I_TIMER2_COMPARE_B_EN) |->
			O_PD_OUT[3] == $past(I_TIMER2_COMPARE_B_OUT);
	endproperty
	a_timer2_compare_b_out: assert property (p_timer2_compare_b_out) else $error("pin 3 value");
	property p_timer0_compare_a_out;
		I_TIMER0_COMPARE_A_EN ##1 run_r |->
			O_PD_OUT[6] == $past(I_TIMER0_COMPARE_A_OUT);
	endproperty
	a_timer0_compare_a_out: assert property (p_timer0_compare_a_out) else $error("pin 6 value");
	property p_timer0_compare_b_out;
		run_r && $past(I_TIMER0_COMPARE_B_EN) |->
			O_PD_OUT[5] == $past(I_TIMER0_COMPARE_B_OUT);
	endproperty
	a_timer0_compare_b_out: assert property (p_timer0_compare_b_out) else $error("pin 5 value");
	property p_sck;
		run_r && $past(I_SYNC_MODE_SELECT) |->
			O_PD_OUT[4] == $past(I_SERIAL_CLOCK_OUT);
	endproperty
	a_sck: assert property (p_sck) else $error("pin 4 value");
	property p_ext_irq_one;
		$rose(O_EXT_IRQ_ONE_IN) |-> ##[0:1] O_PIN_CHANGE_SRC[19];
	endproperty
	a_ext_irq_one: assert property (p_ext_irq_one) else $error("pin 3 source");
	property p_ext_irq_zero;
		$rose(O_EXT_IRQ_ZERO_IN) |-> ##[0:1] O_PIN_CHANGE_SRC[18];
	endproperty
	a_ext_irq_zero: assert property (p_ext_irq_zero) else $error("pin 2 source");
	c_tx: cover property (I_TRANSMITTER_ON);
	c_rx: cover property (I_RECEIVER_ON);
	c_int: cover property ($rose(O_EXT_IRQ_ONE_IN));
endmodule // ppo_port_pin_override_properties
bind ppo_port_pin_override ppo_port_pin_override_properties
	ppo_port_pin_override_properties_i (.I_CLOCK(I_CLOCK),
	.I_RSTN(I_RSTN), .I_TRANSMITTER_ON(I_TRANSMITTER_ON),
	.I_TX_DATA(I_TX_DATA), .I_RECEIVER_ON(I_RECEIVER_ON),
	.I_SYNC_MODE_SELECT(I_SYNC_MODE_SELECT),
	.I_SERIAL_CLOCK_OUT(I_SERIAL_CLOCK_OUT),
	.I_TIMER0_COMPARE_A_EN(I_TIMER0_COMPARE_A_EN),
	.I_TIMER0_COMPARE_A_OUT(I_TIMER0_COMPARE_A_OUT),
	.I_TIMER0_COMPARE_B_EN(I_TIMER0_COMPARE_B_EN),
	.I_TIMER0_COMPARE_B_OUT(I_TIMER0_COMPARE_B_OUT),
	.I_TIMER2_COMPARE_B_EN(I_TIMER2_COMPARE_B_EN),
	.I_TIMER2_COMPARE_B_OUT(I_TIMER2_COMPARE_B_OUT),
	.O_PD_OUT(O_PD_OUT), .O_PD_OE_N(O_PD_OE_N), .O_PD_PULLUP(O_PD_PULLUP),
	.O_PIN_CHANGE_SRC(O_PIN_CHANGE_SRC),
	.O_EXT_IRQ_ZERO_IN(O_EXT_IRQ_ZERO_IN),
	.O_EXT_IRQ_ONE_IN(O_EXT_IRQ_ONE_IN));
`default_nettype wire

//--- verification/ppo_port_pin_override_tb_top.sv
`default_nettype none
`include "ppo_defines.vh"
module ppo_port_pin_override_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
	logic slp = 1'b0, bry = 1'b0, rry = 1'b0;
	wire rxd;
	logic [7:0] awa = 8'h00, ara = 8'h00, ext_b = 8'h00, ext_d = 8'h00;
	logic [6:0] ext_c = 7'h00;
	logic [31:0] wd = 32'h0;
	// Bits: tx on, tx, rx on, sync, sck, timer0_compare_a_out en/val, timer0_compare_b_out en/val, timer2_compare_b_out en/val, ext_irq_zero, ext_irq_one
	logic [12:0] p = 13'h0000;
	int mismatches = 0, n_checks = 0;
	wire awr, wrdy, bv, arr, rv, irq, e0, e1;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [7:0] pb, pd, pbo, pbe, pbp, pdo, pde, pdp;
	wire [6:0] pc, pco, pce, pcp;
	wire [23:16] pcs;
	ppo_port_pin_override ppo_port_pin_override_i (.I_CLOCK(clk),
		.I_RSTN(rstn), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
		.I_WDATA(wd), .I_WSTRB(4'h1), .I_WVALID(wv), .O_WREADY(wrdy),
		.O_BRESP(br), .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara),
		.I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr),
		.O_RVALID(rv), .I_RREADY(rry), .I_PB_IN(pb), .I_PC_IN(pc),
		.I_PD_IN(pd), .I_SLEEP(slp), .I_TRANSMITTER_ON(p[0]),
		.I_TX_DATA(p[1]), .I_RECEIVER_ON(p[2]), .I_SYNC_MODE_SELECT(p[3]),
		.I_SERIAL_CLOCK_OUT(p[4]), .I_TIMER0_COMPARE_A_EN(p[5]),
		.I_TIMER0_COMPARE_A_OUT(p[6]), .I_TIMER0_COMPARE_B_EN(p[7]),
		.I_TIMER0_COMPARE_B_OUT(p[8]), .I_TIMER2_COMPARE_B_EN(p[9]),
		.I_TIMER2_COMPARE_B_OUT(p[10]), .I_EXT_IRQ_ZERO_EN(p[11]),
		.I_EXT_IRQ_ONE_EN(p[12]), .O_PB_OUT(pbo), .O_PB_OE_N(pbe),
		.O_PB_PULLUP(pbp), .O_PC_OUT(pco), .O_PC_OE_N(pce), .O_PC_PULLUP(pcp),
		.O_PD_OUT(pdo), .O_PD_OE_N(pde), .O_PD_PULLUP(pdp),
		.O_PIN_CHANGE_SRC(pcs), .O_EXT_IRQ_ZERO_IN(e0),
		.O_EXT_IRQ_ONE_IN(e1), .O_RX_DATA(rxd), .O_IRQ(irq));
	ppo_pins_model #(.W(8)) ppo_pins_model_b_i (.i_out(pbo), .i_oe_n(pbe),
		.i_pull(pbp), .i_ext(ext_b), .o_pin(pb));
	ppo_pins_model #(.W(7)) ppo_pins_model_c_i (.i_out(pco), .i_oe_n(pce),
		.i_pull(pcp), .i_ext(ext_c), .o_pin(pc));
	ppo_pins_model #(.W(8)) ppo_pins_model_d_i (.i_out(pdo), .i_oe_n(pde),
		.i_pull(pdp), .i_ext(ext_d), .o_pin(pd));
	initial begin
		forever #25 clk = ~clk;
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task to(input logic ok);
		if (!ok) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	// Pin paths run through two sync flops, a sample and an output register
	task s;
		repeat (6) @(posedge clk);
	endtask
	task automatic wr(input logic [4:0] ix, input logic [7:0] d,
			input logic [1:0] er);
		int n;
		logic b;
		@(posedge clk);
		bry <= 1'b1;
		awa <= {1'b0, ix, 2'b00};
		wd <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 40 && !b; n++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			if (bv) begin
				b = 1'b1;
				bry <= 1'b0;
				chk(8'(br), 8'(er));
			end
		end
		to(b);
	endtask
	task automatic rd(input logic [4:0] ix, input logic [7:0] e,
			input logic [1:0] er);
		int n;
		logic b;
		@(posedge clk);
		rry <= 1'b1;
		ara <= {1'b0, ix, 2'b00};
		arv <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 40 && !b; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) begin
				b = 1'b1;
				rry <= 1'b0;
				chk(8'(rr), 8'(er));
				if (er == `PPO_RESP_OKAY) chk(rdat[7:0], e);
			end
		end
		to(b);
	endtask
	task t_regs;
		ext_b <= 8'h3C;
		rd(`PPO_IX_C_DATA, 8'h00, 2'h0);
		rd(`PPO_IX_D_DIR, 8'h00, 2'h0);
		wr(`PPO_IX_C_DATA, 8'hFF, 2'h0);
		rd(`PPO_IX_C_DATA, 8'h7F, 2'h0);
		wr(`PPO_IX_D_DIR, 8'hA5, 2'h0);
		rd(`PPO_IX_D_DIR, 8'hA5, 2'h0);
		wr(`PPO_IX_B_SAMPLE, 8'hFF, 2'h0);
		rd(`PPO_IX_B_SAMPLE, 8'h3C, 2'h0);
		wr(5'h01, 8'h12, `PPO_RESP_SLVERR);
		rd(5'h1F, 8'h00, `PPO_RESP_SLVERR);
		$display("t_regs done");
	endtask
	task t_pull;
		wr(`PPO_IX_B_DATA, 8'hFF, 2'h0);
		wr(`PPO_IX_D_DIR, 8'h01, 2'h0);
		wr(`PPO_IX_D_DATA, 8'h01, 2'h0);
		p <= 13'h0004;
		s;
		chk(pbp, 8'hFF);
		chk(8'(pde[0]), 8'h01);
		chk(8'(pdp[0]), 8'h01);
		chk(8'(rxd), 8'h01);
		wr(`PPO_IX_CORE_CTRL, 8'h10, 2'h0);
		s;
		chk(pbp, 8'h00);
		chk(8'(pdp[0]), 8'h00);
		wr(`PPO_IX_CORE_CTRL, 8'h00, 2'h0);
		p <= 13'h0000;
		$display("t_pull done");
	endtask
	task t_alt;
		wr(`PPO_IX_D_DIR, 8'h78, 2'h0);
		wr(`PPO_IX_D_DATA, 8'hFF, 2'h0);
		p <= 13'h06FB;
		s;
		chk(pdo & 8'h7A, 8'h5A);
		chk(pde, 8'h85);
		chk(pdp, 8'h85);
		p <= 13'h03A9;
		s;
		chk(pdo & 8'h7A, 8'h20);
		p <= 13'h0000;
		wr(`PPO_IX_D_DIR, 8'h00, 2'h0);
		wr(`PPO_IX_D_DATA, 8'h00, 2'h0);
		$display("t_alt done");
	endtask
	task t_pcint;
		slp <= 1'b1;
		wr(`PPO_IX_PC_MASK, 8'h08, 2'h0);
		wr(`PPO_IX_PC_CTRL, 8'h04, 2'h0);
		wr(`PPO_IX_IRQ_MASK, 8'h08, 2'h0);
		ext_d <= 8'h88;
		s;
		chk(pcs, 8'h08);
		chk(8'(irq), 8'h01);
		wr(`PPO_IX_IRQ_STATUS, 8'h08, 2'h0);
		s;
		chk(8'(irq), 8'h00);
		wr(`PPO_IX_IRQ_MASK, 8'h00, 2'h0);
		ext_d <= 8'h04;
		s;
		chk(8'(irq), 8'h00);
		rd(`PPO_IX_IRQ_STATUS, 8'h08, 2'h0);
		p <= 13'h1800;
		wr(`PPO_IX_PC_MASK, 8'h00, 2'h0);
		ext_d <= 8'h8C;
		s;
		chk(pcs, 8'h0C);
		chk(8'(e0), 8'h01);
		chk(8'(e1), 8'h01);
		slp <= 1'b0;
		p <= 13'h0000;
		$display("t_pcint done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs;
		t_pull;
		t_alt;
		t_pcint;
		tally_and_finish;
	end
endmodule // ppo_port_pin_override_tb_top
`default_nettype wire
